// [led_consts.svh]
// Purpose: constants for the board status indicator logic
// Assumes: board clock of 200 MHz
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

`define CLK_PERIOD_NS   5

// register byte offsets
`define OFS_CFG         12'h000
`define OFS_POCL        12'h004
`define OFS_STATUS      12'h008

// field positions
`define CFG_MODE_LSB    0
`define POCL_EN_LSB     0
`define ST_CLK1_BIT     0
`define ST_LV1_BIT      1
`define ST_CLK2_BIT     2
`define ST_LV2_BIT      3
`define ST_ACQ_LSB      4
`define ST_HOST_LSB     6
`define ST_FIRST_LSB    9
`define ST_SECOND_LSB   12

// reset values
`define CFG_MODE_RST    2'h1
`define POCL_RST        2'h0

// link width that counts as full width
`define LANES_FULL      6'h04

// flash half periods and activity timeouts
`define SLOW_HALF_NS    500000000
`define FAST_HALF_NS    62500000
`define PIX_TO_NS       10000
`define LVAL_TO_NS      200000000
`define SLOW_HALF_CYC   (`SLOW_HALF_NS / `CLK_PERIOD_NS)
`define FAST_HALF_CYC   (`FAST_HALF_NS / `CLK_PERIOD_NS)
`define PIX_TO_CYC      (`PIX_TO_NS / `CLK_PERIOD_NS)
`define LVAL_TO_CYC     (`LVAL_TO_NS / `CLK_PERIOD_NS)

`endif

// [led_pkg.sv]
// Purpose: types for the board status indicator logic
// Assumes: nothing beyond the header of constants
// Notes: yellow is red and green lit together
package led_pkg;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } led_t;

  // camera link input configuration, stored in two bits
  typedef enum logic [1:0] {
    CL_BASE,
    CL_MEDIUM,
    CL_FULL,
    CL_EIGHTY
  } cl_mode_t;

  typedef struct packed {
    logic fw_loaded;
    logic fw_safe;
    logic fw_full;
    logic train_fail;
    logic gen2;
    logic [5:0] width;
  } host_stat_t;

endpackage

// [board_status_led_logic.sv]
// Purpose: drives the host-link and camera-cable status indicators
// Assumes: status inputs share CLK; pixel clocks and line valids arrive on their own clocks
// Notes on behaviour
// - host-link indicator steady red while no firmware is loaded.
// - normal firmware, gen2, four lanes: host-link steady green.
// - normal firmware, gen1, four lanes: host-link flashing green.
// - normal firmware, gen2, not four lanes: host-link steady yellow.
// - normal firmware, gen1, not four lanes: host-link flashing yellow.
// - safe firmware: blue, steady at gen2, flashing at gen1, any width.
// - link training failure: host-link flashing red.
// - cable indicator steady red while no pixel clock is seen.
// - pixel clock, no line valid activity and no acquisition: steady green.
// - pixel clock and line valid, no acquisition: slow green flash near 1 Hz.
// - acquisition in progress: fast green flash near 8 Hz.
// - each cable indicator follows only its own connector, independently.
// - full mode: second cable needs both clocks and both line valids.
// - full firmware with first input as base: second indicator always red.
// - detection needs one clock and LVAL, two of each in full or 80-bit.
// - with full firmware the input configuration defaults to medium.
// - camera power enable, once set, holds until board reset.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "led_consts.svh"
`default_nettype none

module board_status_led_logic #(
  parameter logic [31:0] SLOW_HALF = 32'(`SLOW_HALF_CYC),
  parameter logic [31:0] FAST_HALF = 32'(`FAST_HALF_CYC),
  parameter logic [31:0] LVAL_TO   = 32'(`LVAL_TO_CYC)
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [11:0]         PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // status from pcie core and firmware loader
  input  wire led_pkg::host_stat_t HOST_STAT,
  // acquisition engine, bit 0 first cable, bit 1 second cable
  input  wire logic [1:0]          ACQ_ACTIVE,
  // link clocks: 0 first cable, 1 and 2 the two clocks of the second cable
  input  wire logic [2:0]          PIX_CLK,
  input  wire logic [2:0]          LVAL,
  // indicators and camera power
  output led_pkg::led_t            HOST_LINK_STATUS_LED,
  output led_pkg::led_t            FIRST_CABLE_STATUS_LED,
  output led_pkg::led_t            SECOND_CABLE_STATUS_LED,
  output logic      [1:0]          POCL_EN
);

  localparam logic [31:0] PIX_TO = 32'(`PIX_TO_CYC);

  // led colour patterns
  function automatic led_pkg::led_t mk_led(input logic r, input logic g, input logic b);
    led_pkg::led_t l;
    l.red   = r;
    l.green = g;
    l.blue  = b;
    return l;
  endfunction

  // cable indicator selection, shared by both cables
  function automatic led_pkg::led_t cable_led(input logic ck_ok, input logic lv_ok,
                                              input logic acq, input logic slow,
                                              input logic fast);
    led_pkg::led_t l;
    l = mk_led(1'b1, 1'b0, 1'b0);
    if (ck_ok) begin
      if (acq)
        l = mk_led(1'b0, fast, 1'b0);
      else if (lv_ok)
        l = mk_led(1'b0, slow, 1'b0);
      else
        l = mk_led(1'b0, 1'b1, 1'b0);
    end
    return l;
  endfunction

  // ---------------- link domains ----------------
  logic [2:0] ck_tog;
  logic [2:0] lv_tog;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_link
      logic [1:0] rst_sync_q = 2'h0;
      logic [3:0] div_q      = 4'h0;
      logic       lv_q       = 1'b0;
      logic       lt_q       = 1'b0;
      always_ff @(posedge PIX_CLK[g]) begin
        rst_sync_q <= {rst_sync_q[0], RST_N};
      end
      // clock presence: a slow toggle derived from the pixel clock
      always_ff @(posedge PIX_CLK[g]) begin
        if (!rst_sync_q[1]) begin
          div_q <= 4'h0;
        end else begin
          div_q <= div_q + 4'h1;
        end
      end
      // line valid activity: toggle on each rising line valid
      always_ff @(posedge PIX_CLK[g]) begin
        if (!rst_sync_q[1]) begin
          lv_q <= 1'b0;
          lt_q <= 1'b0;
        end else begin
          lv_q <= LVAL[g];
          if (LVAL[g] && !lv_q)
            lt_q <= ~lt_q;
        end
      end
      assign ck_tog[g] = div_q[3];
      assign lv_tog[g] = lt_q;
    end
  endgenerate

  // ---------------- crossing into CLK ----------------
  logic [2:0] ck_s1_q;
  logic [2:0] ck_s2_q;
  logic [2:0] ck_s3_q;
  logic [2:0] lv_s1_q;
  logic [2:0] lv_s2_q;
  logic [2:0] lv_s3_q;

  // no reset: the chain tracks toggle levels through reset, so a level left
  // by a stopped link clock is not taken for a fresh toggle after release
  always_ff @(posedge CLK) begin
    ck_s1_q <= ck_tog;
    ck_s2_q <= ck_s1_q;
    ck_s3_q <= ck_s2_q;
    lv_s1_q <= lv_tog;
    lv_s2_q <= lv_s1_q;
    lv_s3_q <= lv_s2_q;
  end

  // ---------------- activity timers ----------------
  logic [31:0] ck_idle_q [3];
  logic [31:0] lv_idle_q [3];
  logic [2:0]  ck_ok;
  logic [2:0]  lv_ok;

  always_ff @(posedge CLK) begin
    for (int i = 0; i < 3; i++) begin
      if (!RST_N)
        ck_idle_q[i] <= PIX_TO;
      else if (ck_s2_q[i] ^ ck_s3_q[i])
        ck_idle_q[i] <= 32'h0;
      else if (ck_idle_q[i] < PIX_TO)
        ck_idle_q[i] <= ck_idle_q[i] + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    for (int i = 0; i < 3; i++) begin
      if (!RST_N)
        lv_idle_q[i] <= LVAL_TO;
      else if (lv_s2_q[i] ^ lv_s3_q[i])
        lv_idle_q[i] <= 32'h0;
      else if (lv_idle_q[i] < LVAL_TO)
        lv_idle_q[i] <= lv_idle_q[i] + 32'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ck_ok[i] = ck_idle_q[i] < PIX_TO;
      lv_ok[i] = lv_idle_q[i] < LVAL_TO;
    end
  end

  // ---------------- flash dividers ----------------
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  logic        slow_q;
  logic        fast_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slow_cnt_q <= 32'h0;
      slow_q     <= 1'b0;
    end else if (slow_cnt_q >= SLOW_HALF - 32'h1) begin
      slow_cnt_q <= 32'h0;
      slow_q     <= ~slow_q;
    end else begin
      slow_cnt_q <= slow_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fast_cnt_q <= 32'h0;
      fast_q     <= 1'b0;
    end else if (fast_cnt_q >= FAST_HALF - 32'h1) begin
      fast_cnt_q <= 32'h0;
      fast_q     <= ~fast_q;
    end else begin
      fast_cnt_q <= fast_cnt_q + 32'h1;
    end
  end

  // ---------------- registers ----------------
  led_pkg::cl_mode_t mode_q;
  logic [1:0]        pocl_q;
  logic [31:0]       prdata_d;
  logic              hit;
  logic              wr_en;

  assign wr_en = PSEL && PENABLE && PWRITE;

  always_ff @(posedge CLK) begin
    if (!RST_N)
      mode_q <= led_pkg::cl_mode_t'(`CFG_MODE_RST);
    else if (wr_en && PADDR == `OFS_CFG)
      mode_q <= led_pkg::cl_mode_t'(PWDATA[`CFG_MODE_LSB +: 2]);
  end

  // power enable bits only ever set; board reset alone clears them
  always_ff @(posedge CLK) begin
    if (!RST_N)
      pocl_q <= `POCL_RST;
    else if (wr_en && PADDR == `OFS_POCL)
      pocl_q <= pocl_q | PWDATA[`POCL_EN_LSB +: 2];
  end

  assign POCL_EN = pocl_q;

  // ---------------- second cable qualification ----------------
  led_pkg::cl_mode_t eff_mode;
  logic              c2_ck_ok;
  logic              c2_lv_ok;

  // without full firmware the second cable is not in use
  assign eff_mode = HOST_STAT.fw_full ? mode_q : led_pkg::CL_BASE;

  always_comb begin
    case (eff_mode)
      led_pkg::CL_MEDIUM: begin
        c2_ck_ok = ck_ok[1];
        c2_lv_ok = lv_ok[1];
      end
      led_pkg::CL_FULL, led_pkg::CL_EIGHTY: begin
        c2_ck_ok = ck_ok[1] && ck_ok[2];
        c2_lv_ok = lv_ok[1] && lv_ok[2];
      end
      default: begin
        c2_ck_ok = 1'b0;
        c2_lv_ok = 1'b0;
      end
    endcase
  end

  // ---------------- indicators ----------------
  led_pkg::led_t host_d;
  led_pkg::led_t host_q;
  led_pkg::led_t first_q;
  led_pkg::led_t second_q;
  logic          x4;
  logic          blink;

  assign x4    = HOST_STAT.width == `LANES_FULL;
  assign blink = HOST_STAT.gen2 ? 1'b1 : slow_q;

  always_comb begin
    if (!HOST_STAT.fw_loaded)
      host_d = mk_led(1'b1, 1'b0, 1'b0);
    else if (HOST_STAT.train_fail)
      host_d = mk_led(slow_q, 1'b0, 1'b0);
    else if (HOST_STAT.fw_safe)
      host_d = mk_led(1'b0, 1'b0, blink);
    else if (x4)
      host_d = mk_led(1'b0, blink, 1'b0);
    else
      host_d = mk_led(blink, blink, 1'b0);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N)
      host_q <= mk_led(1'b1, 1'b0, 1'b0);
    else
      host_q <= host_d;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      first_q  <= mk_led(1'b1, 1'b0, 1'b0);
      second_q <= mk_led(1'b1, 1'b0, 1'b0);
    end else begin
      first_q  <= cable_led(ck_ok[0], lv_ok[0], ACQ_ACTIVE[0], slow_q, fast_q);
      second_q <= cable_led(c2_ck_ok, c2_lv_ok, ACQ_ACTIVE[1], slow_q, fast_q);
    end
  end

  assign HOST_LINK_STATUS_LED    = host_q;
  assign FIRST_CABLE_STATUS_LED  = first_q;
  assign SECOND_CABLE_STATUS_LED = second_q;

  // ---------------- apb read path ----------------
  always_comb begin
    prdata_d = 32'h0;
    hit      = 1'b1;
    case (PADDR)
      `OFS_CFG:    prdata_d[`CFG_MODE_LSB +: 2] = mode_q;
      `OFS_POCL:   prdata_d[`POCL_EN_LSB +: 2] = pocl_q;
      `OFS_STATUS: begin
        prdata_d[`ST_CLK1_BIT]       = ck_ok[0];
        prdata_d[`ST_LV1_BIT]        = lv_ok[0];
        prdata_d[`ST_CLK2_BIT]       = c2_ck_ok;
        prdata_d[`ST_LV2_BIT]        = c2_lv_ok;
        prdata_d[`ST_ACQ_LSB +: 2]   = ACQ_ACTIVE;
        prdata_d[`ST_HOST_LSB +: 3]  = host_q;
        prdata_d[`ST_FIRST_LSB +: 3] = first_q;
        prdata_d[`ST_SECOND_LSB +: 3] = second_q;
      end
      default:     hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N)
      PRDATA <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= prdata_d;
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_nofw_red: assert property (!HOST_STAT.fw_loaded |=> host_q == 3'h4)
    else $error("host indicator not red without firmware");
  chk_gen2_green: assert property (HOST_STAT.fw_loaded && !HOST_STAT.train_fail && !HOST_STAT.fw_safe
      && HOST_STAT.gen2 && x4 |=> host_q == 3'h2)
    else $error("host indicator not steady green");
  chk_gen1_flash: assert property (HOST_STAT.fw_loaded && !HOST_STAT.train_fail && !HOST_STAT.fw_safe
      && !HOST_STAT.gen2 && x4 |=> host_q.green == $past(slow_q) && !host_q.red)
    else $error("host indicator not flashing green");
  chk_narrow_yellow: assert property (HOST_STAT.fw_loaded && !HOST_STAT.train_fail && !HOST_STAT.fw_safe
      && !x4 |=> host_q.red == host_q.green && !host_q.blue)
    else $error("host indicator not yellow");
  chk_safe_blue: assert property (HOST_STAT.fw_loaded && !HOST_STAT.train_fail && HOST_STAT.fw_safe
      |=> !host_q.red && !host_q.green && host_q.blue == ($past(HOST_STAT.gen2) || $past(slow_q)))
    else $error("safe firmware indication wrong");
  chk_train_red: assert property (HOST_STAT.fw_loaded && HOST_STAT.train_fail
      |=> host_q == {$past(slow_q), 2'b00})
    else $error("training failure indication wrong");
  chk_noclk_red: assert property (!ck_ok[0] |=> first_q == 3'h4)
    else $error("first cable not red without clock");
  chk_acq_fast: assert property (ck_ok[0] && ACQ_ACTIVE[0] |=> first_q.green == $past(fast_q))
    else $error("acquisition flash wrong");
  chk_full_two: assert property (HOST_STAT.fw_full && mode_q == led_pkg::CL_FULL && !ck_ok[2]
      |=> second_q == 3'h4)
    else $error("full mode accepted one clock");
  chk_base_red: assert property (HOST_STAT.fw_full && mode_q == led_pkg::CL_BASE
      |=> second_q == 3'h4)
    else $error("second cable not red in base");
  chk_pocl_hold: assert property (pocl_q[0] |=> pocl_q[0])
    else $error("camera power dropped before reset");
  chk_mode_dflt: assert property (disable iff (1'b0) !RST_N |=> mode_q == led_pkg::CL_MEDIUM)
    else $error("mode not medium after reset");
  chk_slow_bound: assert property (slow_cnt_q < SLOW_HALF)
    else $error("slow divider overran");

  cov_gen2_green: cover property (host_q == 3'h2 ##1 host_q == 3'h2);
  cov_first_acq: cover property (ck_ok[0] && ACQ_ACTIVE[0]);
  cov_full_ok: cover property (c2_ck_ok && eff_mode == led_pkg::CL_FULL);

endmodule

`default_nettype wire

// [cam_model.sv]
// Purpose: camera side of the cables, three gated pixel clocks with line valid
// Assumes: enables from the bench may change at any time
// Notes: a stopped clock rests low; line valid idles low
`timescale 1ns/1ps
`default_nettype none
module cam_model (
  input  wire logic [2:0] clk_en,
  input  wire logic [2:0] lval_en,
  output logic      [2:0] pix_clk,
  output wire logic [2:0] lval
);
  logic       base_clk = 1'b0;
  logic [2:0] gate_q   = 3'h0;
  initial begin
    #13.7;
    forever #40 base_clk = ~base_clk;
  end
  // gates move only while the clock is low, so no runt pulses
  always @(negedge base_clk) gate_q <= clk_en;
  assign pix_clk = {3{base_clk}} & gate_q;
  for (genvar i = 0; i < 3; i++) begin : g_lv
    logic q = 1'b0;
    always @(posedge pix_clk[i]) q <= lval_en[i] ? ~q : 1'b0;
    assign lval[i] = q;
  end
endmodule
`default_nettype wire

// [board_status_led_logic_test.sv]
// Purpose: self-checking bench for the status indicator logic
// Assumes: short flash counts and line valid timeout set through parameters
// Notes: flashes are judged by on-time and toggle count over sixteen half periods
`timescale 1ns/1ps
`default_nettype none
`define CMP(nm, e, g) begin checks_done++; if ((g) !== (e)) begin $display("BAD %s exp %0h got %0h", nm, e, g); n_errors++; end end
module board_status_led_logic_test;
  localparam int SLOW = 8;
  localparam int FAST = 2;
  logic                 clk         = 1'b0;
  logic                 rst_n       = 1'b0;
  logic                 psel        = 1'b0;
  logic                 penable     = 1'b0;
  logic                 pwrite      = 1'b0;
  logic [11:0]          paddr       = 12'h000;
  logic [31:0]          pwdata      = 32'h0;
  led_pkg::host_stat_t  hs          = '0;
  logic [1:0]           acq         = 2'h0;
  logic [2:0]           clk_en      = 3'h0;
  logic [2:0]           lv_en       = 3'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [2:0]           pix;
  logic [2:0]           lv;
  logic [1:0]           pocl;
  led_pkg::led_t        led [3];
  logic [31:0]          rd;
  logic                 er;
  int                   n_errors    = 0;
  int                   checks_done = 0;
  int                   cyc         = 0;

  always #2.5 clk = ~clk;

  board_status_led_logic #(.SLOW_HALF(32'(SLOW)), .FAST_HALF(32'(FAST)), .LVAL_TO(32'hC8))
  board_status_led_logic_inst (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HOST_STAT(hs),
    .ACQ_ACTIVE(acq), .PIX_CLK(pix), .LVAL(lv), .HOST_LINK_STATUS_LED(led[0]),
    .FIRST_CABLE_STATUS_LED(led[1]), .SECOND_CABLE_STATUS_LED(led[2]), .POCL_EN(pocl)
  );

  cam_model cam_model_inst (.clk_en(clk_en), .lval_en(lv_en), .pix_clk(pix), .lval(lv));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CMP("reg", e, rd)
  endtask

  // steady when half is zero, otherwise a flash between e and dark
  task automatic observe(int i, led_pkg::led_t e, int half);
    int n, eo, et, n_on, n_tog, n_bad;
    led_pkg::led_t p;
    n = half ? 16 * half : 8;
    eo = half ? n / 2 : n;
    et = half ? 16 : 0;
    n_on = 0;
    n_tog = 0;
    n_bad = 0;
    repeat (20) @(posedge clk);
    #1;
    p = led[i];
    repeat (n) begin
      @(posedge clk);
      #1;
      if (led[i] === e) n_on++;
      else if (half == 0 || led[i] !== 3'h0) n_bad++;
      if (led[i] !== p) n_tog++;
      p = led[i];
    end
    `CMP("led_colour", 1'b1, n_bad == 0)
    `CMP("led_duty", 1'b1, n_on >= eo - half && n_on <= eo + half)
    `CMP("led_toggles", 1'b1, n_tog >= et - 1 && n_tog <= et + 1)
  endtask

  function automatic led_pkg::led_t host_exp(led_pkg::host_stat_t s, output int half);
    half = s.gen2 ? 0 : SLOW;
    if (!s.fw_loaded) begin
      half = 0;
      return 3'h4;
    end
    if (s.train_fail) begin
      half = SLOW;
      return 3'h4;
    end
    if (s.fw_safe) return 3'h1;
    return (s.width == 6'h04) ? 3'h2 : 3'h6;
  endfunction

  task automatic host_case(logic [10:0] v);
    led_pkg::led_t e;
    int h;
    hs <= v;
    e = host_exp(v, h);
    observe(0, e, h);
  endtask

  task automatic cam_set(logic [2:0] c, logic [2:0] l, logic [1:0] a, int w);
    clk_en <= c;
    lv_en  <= l;
    acq    <= a;
    repeat (w) @(posedge clk);
  endtask

  initial begin
    void'($urandom(77));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(12'h000, 32'h1);
    rchk(12'h004, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    `CMP("unmapped_err", 1'b1, er)
    `CMP("unmapped_data", 32'h0, rd)
    apb(1'b1, 12'h004, 32'h1);
    rchk(12'h004, 32'h1);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h004, 32'h0);
    rchk(12'h004, 32'h3);
    `CMP("pocl_pin", 2'h3, pocl)
    $display("test registers done");
    host_case(11'h044);
    host_case(11'h444);
    host_case(11'h404);
    host_case(11'h448);
    host_case(11'h440);
    host_case(11'h408);
    host_case(11'h641);
    host_case(11'h604);
    host_case(11'h4C4);
    repeat (10) host_case(11'($urandom));
    $display("test host done");
    hs <= 11'h544;
    cam_set(3'h1, 3'h0, 2'h0, 600);
    observe(1, 3'h2, 0);
    observe(2, 3'h4, 0);
    cam_set(3'h3, 3'h0, 2'h0, 600);
    observe(2, 3'h2, 0);
    cam_set(3'h3, 3'h1, 2'h0, 100);
    observe(1, 3'h2, SLOW);
    observe(2, 3'h2, 0);
    cam_set(3'h3, 3'h1, 2'h1, 10);
    observe(1, 3'h2, FAST);
    apb(1'b0, 12'h008, 32'h0);
    `CMP("status_acq", 2'h1, rd[5:4])
    `CMP("status_link", 4'h7, rd[3:0])
    `CMP("status_host", 3'h2, rd[8:6])
    `CMP("status_second", 3'h2, rd[14:12])
    apb(1'b1, 12'h000, 32'h2);
    observe(2, 3'h4, 0);
    cam_set(3'h7, 3'h3, 2'h0, 600);
    observe(2, 3'h2, 0);
    cam_set(3'h7, 3'h7, 2'h0, 100);
    observe(2, 3'h2, SLOW);
    cam_set(3'h7, 3'h7, 2'h2, 10);
    observe(2, 3'h2, FAST);
    observe(1, 3'h2, SLOW);
    acq <= 2'h0;
    apb(1'b1, 12'h000, 32'h3);
    observe(2, 3'h2, SLOW);
    apb(1'b1, 12'h000, 32'h0);
    observe(2, 3'h4, 0);
    observe(1, 3'h2, SLOW);
    apb(1'b1, 12'h000, 32'h2);
    hs <= 11'h444;
    observe(2, 3'h4, 0);
    cam_set(3'h7, 3'h0, 2'h0, 400);
    observe(1, 3'h2, 0);
    cam_set(3'h0, 3'h0, 2'h3, 2600);
    observe(1, 3'h4, 0);
    observe(2, 3'h4, 0);
    $display("test cables done");
    rst_n <= 1'b0;
    repeat (40) @(posedge clk);
    `CMP("pocl_reset", 2'h0, pocl)
    rst_n <= 1'b1;
    rchk(12'h000, 32'h1);
    rchk(12'h004, 32'h0);
    observe(1, 3'h4, 0);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
